// ### logic/fetch_ctl_map.vh
/*
  constants for the instruction fetch cycle controller: cycle points,
  cycle point timing, first address source selects, reset values.
  assumes: included by bare name from files under logic/.
*/
`ifndef FETCH_CTL_MAP_VH
`define FETCH_CTL_MAP_VH

// cycle clock: 8 points over one 1.4 us cpu cycle
`define FC_POINTS 8
`define FC_CYCLE_NS 1400
`define FC_SYS_MHZ 250
// one point lasts cycle/8 ns; rounded down to whole clocks
`define FC_POINT_NS (`FC_CYCLE_NS / `FC_POINTS)
`define FC_POINT_CYC ((`FC_POINT_NS * `FC_SYS_MHZ) / 1000)

// cycle points where things happen
`define FC_PT_START 3'h0
`define FC_PT_UPDATE 3'h1
`define FC_PT_XLATE 3'h3
`define FC_PT_BUS 3'h4
`define FC_PT_FLAG 3'h5
`define FC_PT_ADDR 3'h6
`define FC_PT_LATE 3'h2

// first address source select
`define FC_SRC_CTR 2'h0
`define FC_SRC_HOLD 2'h1
`define FC_SRC_BACKUP 2'h2

// reset values and the store-trap opcode
`define FC_CTR_RST 15'h0000
`define FC_WORD_RST 36'h000000000
`define FC_OPC_TRAP 10'h001

`endif

// ### logic/cycle_point_timer.v
/*
  eight point cpu cycle clock: steps the cycle point every point period.
  assumes: one system clock; hold_in comes from logic on that clock.
*/
`timescale 1ns/100ps
`default_nettype none
`include "fetch_ctl_map.vh"

module cycle_point_timer #(
  parameter POINT_CYC = `FC_POINT_CYC
) (
  input wire sys_clk_in,
  input wire rst_in,
  input wire hold_in,
  output reg [2:0] point_out,
  output reg step_out
);

  reg [7:0] div_r; // clocks spent in the current point
  wire div_end;

  assign div_end = (div_r == POINT_CYC[7:0] - 8'h01);

  // divider and point counter; hold freezes the cycle at its point
  always @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      div_r <= 8'h00;
      point_out <= 3'h7;
      step_out <= 1'b0;
    end else begin
      step_out <= 1'b0;
      if (hold_in) begin
        div_r <= 8'h00; // restart the point once released
      end else if (div_end) begin
        div_r <= 8'h00;
        point_out <= point_out + 3'h1; // wraps 7 -> 0
        step_out <= 1'b1;
      end else begin
        div_r <= div_r + 8'h01;
      end
    end
  end

endmodule

`default_nettype wire

// ### logic/index_adder.v
/*
  index adders for the 15 bit address field (bits 3..17, 17 lowest).
  assumes: purely combinational; caller registers the result.
*/
`timescale 1ns/100ps
`default_nettype none

module index_adder #(
  parameter W = 15
) (
  input wire [W-1:0] addr_in,
  input wire carry17_in,
  input wire ones_in,
  output wire [W-1:0] sum_out
);

  wire [W-1:0] ones_field; // ones into bits 3..16, never bit 17

  assign ones_field = ones_in ? {{(W-1){1'b1}}, 1'b0} : {W{1'b0}};
  // a one into bit 17 increments; with bits 3..16 it decrements
  assign sum_out = addr_in + ones_field + {{(W-1){1'b0}}, carry17_in};

endmodule

`default_nettype wire

// ### logic/fetch_cycle_ctl.v
/*
  instruction fetch cycle control: fetch flag with early/late copies,
  dual address generation for even/odd memory, counter update and
  storage bus routing into opcode, storage, tag and backup registers.
  assumes: every input comes from logic on sys_clk_in; core storage
  holds both words steady on the buses from point 4 of the fetch cycle.

  // How it works
  // - skip set: cancel overlap, force fetch
  // - conflict: wait for opcode op end, fetch
  // - backup needs e/l: enter it, else wait
  // - fetch flag set at point five
  // - fetch logically begins at point zero
  // - buffer interrupt blocks fetch flag outputs
  // - flag clears at five; early/late copies continue
  // - extra-late fetch decrements counter for halt
  // - one source gives first address, adders too
  // - second address only overlap and not diagnostic
  // - second address is first plus or minus one
  // - one into bit 17; decrement adds ones
  // - one path stores adder result for counter
  // - held value matches second fetched word
  // - channel trap routes buffer address to memory
  // - point one: held address into counter unchanged
  // - decrement: originating register; increment: receiving register
  // - counter correct: block; trap transfer loads one
  // - external trap: drop words, set store-trap bit
  // - storage bus loads storage, tag, opcode, backup
  // - eight point cycle clock, 1.4 us
  // - counter parity picks bus for opcode register
*/
`timescale 1ns/100ps
`default_nettype none
`include "fetch_ctl_map.vh"

module fetch_cycle_ctl #(
  parameter POINT_CYC = `FC_POINT_CYC,
  parameter AW = 15
) (
  input wire sys_clk_in,
  input wire rst_in,
  input wire skip_flag_in,
  input wire overlap_conflict_in,
  input wire backup_needs_el_in,
  input wire opcode_op_done_in,
  input wire buffer_interrupt_in,
  input wire halt_transfer_op_in,
  input wire overlap_mode_in,
  input wire diag_mode_in,
  input wire channel_trap_in,
  input wire [AW-1:0] buffer_addr_in,
  input wire [1:0] first_src_in,
  input wire decrement_in,
  input wire update_to_backup_in,
  input wire counter_correct_in,
  input wire trap_mode_in,
  input wire cond_xfer_ok_in,
  input wire external_trap_in,
  input wire prefix_load_in,
  input wire long_set_in,
  input wire [0:35] storage_bus_even_in,
  input wire [0:35] storage_bus_odd_in,
  output reg fetch_flag_out,
  output reg fetch_addr_gate_out,
  output reg fetch_early_out,
  output reg fetch_late_out,
  output reg fetch_xlate_out,
  output reg el_cycle_out,
  output reg [2:0] cycle_point_out,
  output reg [AW-1:0] mem_addr_even_out,
  output reg [AW-1:0] mem_addr_odd_out,
  output reg mem_addr_even_valid_out,
  output reg mem_addr_odd_valid_out,
  output reg [AW-1:0] instr_counter_out,
  output reg [AW-1:0] addr_hold_reg_out,
  output reg [0:9] opcode_reg_out,
  output reg [0:35] storage_word_reg_out,
  output reg [0:2] tag_field_reg_out,
  output reg [0:35] instr_backup_reg_out
);

  wire [2:0] point; // current cycle point
  wire step; // one clock pulse on entering a point
  reg fetch_r; // fetch-cycle trigger
  reg early_r; // early copy: point 0 to end of cycle
  reg late_r; // late copy: point 2 to end of cycle
  reg addr_r; // addressing gate: point 6 onward
  reg dec_r; // held address was decremented
  reg dest_backup_r; // held address sits in backup register
  reg [1:0] src_r; // register that gave the first address
  reg [AW-1:0] first_r; // first address of the pair
  reg [AW-1:0] add_a; // adder operand
  reg add_c; // carry into bit 17
  reg add_ones; // ones into bits 3..16
  wire [AW-1:0] add_sum; // adder result
  wire blocked; // buffer cycles pending
  wire at_flag;
  wire at_addr;
  wire at_start;
  wire at_late;
  wire at_update;
  wire at_xlate;
  wire at_bus;
  wire go_fetch; // decision taken at point 5
  reg [AW-1:0] first_sel; // selected first address
  reg [0:35] to_opcode; // bus bound for opcode side
  reg [0:35] to_backup; // bus bound for backup register

  // backup register address field: bits 21..35
  function [AW-1:0] addr_of;
    input [0:35] w;
    begin
      addr_of = w[21:35];
    end
  endfunction

  assign blocked = buffer_interrupt_in;
  assign at_flag = step && point == `FC_PT_FLAG;
  assign at_addr = step && point == `FC_PT_ADDR;
  assign at_start = step && point == `FC_PT_START;
  assign at_late = step && point == `FC_PT_LATE;
  assign at_update = step && point == `FC_PT_UPDATE && early_r;
  assign at_xlate = step && point == `FC_PT_XLATE && early_r;
  assign at_bus = step && point == `FC_PT_BUS && early_r;

  // next-cycle decision: skip, conflict, or backup e/l test
  assign go_fetch = skip_flag_in ? 1'b1 :
    overlap_conflict_in ? opcode_op_done_in :
    (!backup_needs_el_in && opcode_op_done_in);

  // cycle clock; frozen while a fetch waits on buffer cycles
  cycle_point_timer #(
    .POINT_CYC(POINT_CYC)
  ) u_timer (
    .sys_clk_in(sys_clk_in),
    .rst_in(rst_in),
    .hold_in(fetch_r && blocked),
    .point_out(point),
    .step_out(step)
  );

  // first address: exactly one of counter, hold reg, backup field
  always @* begin
    case (first_src_in)
      `FC_SRC_HOLD: first_sel = addr_hold_reg_out;
      `FC_SRC_BACKUP: first_sel = addr_of(instr_backup_reg_out);
      default: first_sel = instr_counter_out;
    endcase
  end

  // adder operand and injections by phase
  always @* begin
    add_a = first_sel;
    add_c = 1'b1; // bit 17 one at point 6
    add_ones = decrement_in;
    if (at_update) begin
      add_c = 1'b0; // pass through unchanged
      add_ones = 1'b0;
      if (counter_correct_in) begin
        add_a = {AW{1'b0}};
        add_c = trap_mode_in && cond_xfer_ok_in; // loads 00001
      end else if (dec_r ? (src_r == `FC_SRC_BACKUP) : dest_backup_r) begin
        add_a = addr_of(instr_backup_reg_out);
      end else if (dec_r && src_r == `FC_SRC_CTR) begin
        add_a = first_r; // counter gave the address
      end else begin
        add_a = addr_hold_reg_out;
      end
    end else if (at_xlate) begin
      add_a = instr_counter_out;
      add_ones = 1'b1; // minus one for halt
    end
  end

  index_adder #(
    .W(AW)
  ) u_adder (
    .addr_in(add_a),
    .carry17_in(add_c),
    .ones_in(add_ones),
    .sum_out(add_sum)
  );

  // storage bus routing by parity of the already-advanced counter
  always @* begin
    if (instr_counter_out[0]) begin
      to_opcode = storage_bus_even_in;
      to_backup = storage_bus_odd_in;
    end else begin
      to_opcode = storage_bus_odd_in;
      to_backup = storage_bus_even_in;
    end
  end

  // fetch trigger and its delayed copies
  always @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      fetch_r <= 1'b0;
      early_r <= 1'b0;
      late_r <= 1'b0;
      addr_r <= 1'b0;
      el_cycle_out <= 1'b0;
    end else begin
      if (at_flag) begin
        // set or cleared at point 5
        fetch_r <= go_fetch;
        el_cycle_out <= !skip_flag_in && !overlap_conflict_in
          && backup_needs_el_in;
        addr_r <= 1'b0;
      end
      if (at_addr) begin
        addr_r <= fetch_r; // addressing gates from point 6
      end
      if (at_start) begin
        early_r <= fetch_r; // logical start
        late_r <= 1'b0;
      end
      if (at_late) begin
        late_r <= early_r; // lasts to cycle end
      end
    end
  end

  // registered flag outputs, blocked while buffer cycles pend
  always @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      fetch_flag_out <= 1'b0;
      fetch_addr_gate_out <= 1'b0;
      fetch_early_out <= 1'b0;
      fetch_late_out <= 1'b0;
      cycle_point_out <= 3'h7;
    end else begin
      fetch_flag_out <= fetch_r && !blocked;
      fetch_addr_gate_out <= addr_r && !blocked;
      fetch_early_out <= early_r && !blocked;
      fetch_late_out <= late_r && !blocked;
      cycle_point_out <= point;
    end
  end

  // address gating to memory and temporary holding at point 6
  always @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      mem_addr_even_out <= {AW{1'b0}};
      mem_addr_odd_out <= {AW{1'b0}};
      mem_addr_even_valid_out <= 1'b0;
      mem_addr_odd_valid_out <= 1'b0;
      addr_hold_reg_out <= {AW{1'b0}};
      first_r <= {AW{1'b0}};
      dec_r <= 1'b0;
      dest_backup_r <= 1'b0;
      src_r <= `FC_SRC_CTR;
    end else if (at_flag) begin
      mem_addr_even_valid_out <= 1'b0;
      mem_addr_odd_valid_out <= 1'b0;
    end else if (at_addr && fetch_r) begin
      if (channel_trap_in) begin
        // trap location from buffer address register
        mem_addr_even_out <= buffer_addr_in;
        mem_addr_odd_out <= buffer_addr_in;
        mem_addr_even_valid_out <= !buffer_addr_in[0];
        mem_addr_odd_valid_out <= buffer_addr_in[0];
      end else begin
        if (first_sel[0]) begin
          mem_addr_odd_out <= first_sel;
          mem_addr_odd_valid_out <= 1'b1;
          mem_addr_even_out <= add_sum;
          mem_addr_even_valid_out <= overlap_mode_in && !diag_mode_in;
        end else begin
          mem_addr_even_out <= first_sel;
          mem_addr_even_valid_out <= 1'b1;
          mem_addr_odd_out <= add_sum;
          mem_addr_odd_valid_out <= overlap_mode_in && !diag_mode_in;
        end
        // one update path: hold reg or backup field
        if (!update_to_backup_in) begin
          addr_hold_reg_out <= add_sum;
        end
        first_r <= first_sel;
        dec_r <= decrement_in;
        dest_backup_r <= update_to_backup_in;
        src_r <= first_src_in;
      end
    end
  end

  // counter update at point 1, halt decrement at point 3
  always @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      instr_counter_out <= `FC_CTR_RST;
      fetch_xlate_out <= 1'b0;
    end else begin
      fetch_xlate_out <= 1'b0;
      if (at_update) begin
        if (!counter_correct_in || (trap_mode_in && cond_xfer_ok_in)) begin
          instr_counter_out <= add_sum;
        end
      end else if (at_xlate && halt_transfer_op_in) begin
        instr_counter_out <= add_sum; // true halt address
        fetch_xlate_out <= 1'b1;
      end
    end
  end

  // storage bus loads at point 4; long set repeats into backup at 5
  always @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      opcode_reg_out <= 10'h000;
      storage_word_reg_out <= `FC_WORD_RST;
      tag_field_reg_out <= 3'h0;
      instr_backup_reg_out <= `FC_WORD_RST;
    end else if (at_addr && fetch_r && !channel_trap_in && update_to_backup_in) begin
      instr_backup_reg_out[21:35] <= add_sum; // held next address
    end else if (at_bus) begin
      if (external_trap_in) begin
        opcode_reg_out <= `FC_OPC_TRAP; // store-trap bit 9
      end else begin
        // words present by point 4
        storage_word_reg_out <= to_opcode;
        tag_field_reg_out <= to_opcode[18:20];
        if (prefix_load_in) begin
          opcode_reg_out <= {to_opcode[0], 7'h00, to_opcode[1:2]};
        end else begin
          opcode_reg_out <= {to_opcode[0], to_opcode[3:11]};
        end
        instr_backup_reg_out <= to_backup; // short set pulse
      end
    end else if (step && point == `FC_PT_FLAG && early_r && long_set_in
        && !external_trap_in) begin
      instr_backup_reg_out <= storage_word_reg_out; // long set
    end
  end

endmodule

`default_nettype wire

// ### dv/core_store_model.sv
/* even and odd core storage banks facing the fetch controller.
   assumes: addresses stand at point 7, words wanted at point 4. */
`timescale 1ns/100ps
`default_nettype none
module core_store_model (
  input wire logic clk_in,
  input wire logic [2:0] point_in,
  input wire logic [14:0] addr_even_in,
  input wire logic [14:0] addr_odd_in,
  input wire logic even_valid_in,
  input wire logic odd_valid_in,
  output logic [0:35] bus_even_out = 36'h0,
  output logic [0:35] bus_odd_out = 36'h0
);
  logic [14:0] ae_r; // even bank address
  logic [14:0] ao_r; // odd bank address
  logic ve_r = 1'b0; // even bank addressed
  logic vo_r = 1'b0; // odd bank addressed
  logic [0:35] junk_r = 36'h5a5a5a5a5; // filler off the window
  // words stand from point 3 to 5 only, filler otherwise
  always @(negedge clk_in) begin
    junk_r <= ~junk_r;
    if (point_in == 3'h7) begin
      ae_r <= addr_even_in;
      ao_r <= addr_odd_in;
      ve_r <= even_valid_in;
      vo_r <= odd_valid_in;
    end
    bus_even_out <= (ve_r && point_in inside {3, 4, 5}) ? {ae_r[5:0], ~ae_r, ae_r} : junk_r;
    bus_odd_out <= (vo_r && point_in inside {3, 4, 5}) ? {ao_r[5:0], ~ao_r, ao_r} : ~junk_r;
  end
endmodule
`default_nettype wire

// ### dv/fetch_ctl_checker.sv
/* assertions on the fetch cycle controller ports.
   assumes: bound into fetch_cycle_ctl; one clock domain. */
`timescale 1ns/100ps
`default_nettype none
module fetch_ctl_checker #(
  parameter POINT_CYC = 43,
  parameter AW = 15
) (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic buffer_interrupt_in,
  input wire logic fetch_flag_out,
  input wire logic fetch_early_out,
  input wire logic fetch_late_out,
  input wire logic fetch_xlate_out,
  input wire logic [2:0] cycle_point_out,
  input wire logic [AW-1:0] mem_addr_even_out,
  input wire logic [AW-1:0] mem_addr_odd_out,
  input wire logic mem_addr_even_valid_out,
  input wire logic mem_addr_odd_valid_out,
  input wire logic [AW-1:0] instr_counter_out,
  input wire logic [0:35] storage_word_reg_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);
  logic [2:0] pt_r; // point seen last clock
  int dwell_r; // clocks the point has stood
  logic [2:0] blk_r; // recent buffer interrupt history
  // dwell counter and interrupt history
  always @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      pt_r <= 3'h7;
      dwell_r <= 0;
      blk_r <= 3'h0;
    end else begin
      pt_r <= cycle_point_out;
      dwell_r <= (cycle_point_out != pt_r) ? 0 : dwell_r + 1;
      blk_r <= {blk_r[1:0], buffer_interrupt_in};
    end
  end
  a_flag_blocked: assert property (buffer_interrupt_in [*3] |-> !fetch_flag_out)
    else $error("fetch flag under buffer interrupt");
  a_point_step: assert property (cycle_point_out != pt_r |-> cycle_point_out == pt_r + 3'h1)
    else $error("cycle point skipped");
  a_point_dwell: assert property (cycle_point_out != pt_r |-> dwell_r >= POINT_CYC - 1)
    else $error("cycle point too short");
  a_flag_at_five: assert property ($rose(fetch_flag_out) |-> cycle_point_out == 3'h5 || |blk_r)
    else $error("fetch flag rose off point 5");
  a_early_at_zero: assert property ($rose(fetch_early_out) |-> cycle_point_out == 3'h0 || |blk_r)
    else $error("early copy rose off point 0");
  a_late_at_two: assert property ($rose(fetch_late_out) |-> cycle_point_out == 3'h2 || |blk_r)
    else $error("late copy rose off point 2");
  a_xlate_pulse: assert property (fetch_xlate_out |-> cycle_point_out == 3'h3 ##1 !fetch_xlate_out)
    else $error("extra late pulse wrong");
  a_bank_parity: assert property (!(mem_addr_even_valid_out && mem_addr_even_out[0])
    && !(mem_addr_odd_valid_out && !mem_addr_odd_out[0])) else $error("address in wrong bank");
  a_second_adjacent: assert property (mem_addr_even_valid_out && mem_addr_odd_valid_out |->
    mem_addr_even_out + 1'b1 == mem_addr_odd_out || mem_addr_odd_out + 1'b1 == mem_addr_even_out)
    else $error("second address not adjacent");
  a_counter_moment: assert property ($changed(instr_counter_out) |-> cycle_point_out inside {1, 3})
    else $error("counter moved off point 1 or 3");
  a_load_moment: assert property ($changed(storage_word_reg_out) |-> cycle_point_out == 3'h4)
    else $error("storage word loaded off point 4");
endmodule
bind fetch_cycle_ctl fetch_ctl_checker #(.POINT_CYC(POINT_CYC), .AW(AW)) u_chk (
  .sys_clk_in(sys_clk_in), .rst_in(rst_in), .buffer_interrupt_in(buffer_interrupt_in),
  .fetch_flag_out(fetch_flag_out), .fetch_early_out(fetch_early_out),
  .fetch_late_out(fetch_late_out), .fetch_xlate_out(fetch_xlate_out),
  .cycle_point_out(cycle_point_out), .mem_addr_even_out(mem_addr_even_out),
  .mem_addr_odd_out(mem_addr_odd_out), .mem_addr_even_valid_out(mem_addr_even_valid_out),
  .mem_addr_odd_valid_out(mem_addr_odd_valid_out), .instr_counter_out(instr_counter_out),
  .storage_word_reg_out(storage_word_reg_out));
`default_nettype wire

// ### dv/instruction_fetch_cycle_control_bench.sv
/* bench for the fetch cycle controller against a reference model.
   assumes: design, checker and storage model compiled first. */
`timescale 1ns/100ps
`default_nettype none
`include "fetch_ctl_map.vh"
`define CHK(got, exp, msg) begin compares++; if ((got) !== (exp)) begin miscompares++; \
  $display("CHECK FAILED %0t %s", $time, msg); end end
module instruction_fetch_cycle_control_bench;
  logic sys_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic skip_flag_in, overlap_conflict_in, backup_needs_el_in, opcode_op_done_in;
  logic buffer_interrupt_in, halt_transfer_op_in, overlap_mode_in, diag_mode_in;
  logic channel_trap_in, decrement_in, update_to_backup_in, counter_correct_in;
  logic trap_mode_in, cond_xfer_ok_in, external_trap_in, prefix_load_in, long_set_in;
  logic [14:0] buffer_addr_in;
  logic [1:0] first_src_in;
  logic [0:35] storage_bus_even_in, storage_bus_odd_in;
  logic fetch_flag_out, fetch_addr_gate_out, fetch_early_out, fetch_late_out;
  logic fetch_xlate_out, el_cycle_out, mem_addr_even_valid_out, mem_addr_odd_valid_out;
  logic [2:0] cycle_point_out;
  logic [14:0] mem_addr_even_out, mem_addr_odd_out, instr_counter_out, addr_hold_reg_out;
  logic [0:9] opcode_reg_out;
  logic [0:35] storage_word_reg_out, instr_backup_reg_out;
  logic [0:2] tag_field_reg_out;
  int miscompares = 0;
  int compares = 0;
  logic [14:0] c, ae, ao, a2; // model counter and bank addresses
  logic ve, vo, d, x; // model valids, decrement, trap
  logic [0:35] ow, bw; // expected opcode-side and backup words
  logic [2:0] pf; // point frozen under interrupt
  always #2 sys_clk_in = ~sys_clk_in; // 250 MHz
  fetch_cycle_ctl #(.POINT_CYC(4), .AW(15)) u_dut (.*);
  core_store_model u_mem (.clk_in(sys_clk_in), .point_in(cycle_point_out),
    .addr_even_in(mem_addr_even_out), .addr_odd_in(mem_addr_odd_out),
    .even_valid_in(mem_addr_even_valid_out), .odd_valid_in(mem_addr_odd_valid_out),
    .bus_even_out(storage_bus_even_in), .bus_odd_out(storage_bus_odd_in));
  // word the storage banks hold at an address
  function automatic logic [0:35] word(input logic [14:0] a);
    return {a[5:0], ~a, a};
  endfunction
  // verdict and end of run
  task automatic final_report();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // wait for a point, then let its results settle
  task automatic wait_pt(input logic [2:0] p);
    int n;
    n = 0;
    while (cycle_point_out !== p && n < 400) begin
      @(negedge sys_clk_in);
      n++;
    end
    if (n >= 400) begin
      miscompares++;
      $display("CHECK FAILED %0t point wait timed out", $time);
      final_report();
    end
    repeat (2) @(negedge sys_clk_in);
  endtask
  initial begin
    {skip_flag_in, overlap_conflict_in, backup_needs_el_in, opcode_op_done_in} = '0;
    {buffer_interrupt_in, halt_transfer_op_in, overlap_mode_in, diag_mode_in} = '0;
    {channel_trap_in, decrement_in, update_to_backup_in, counter_correct_in} = '0;
    {trap_mode_in, cond_xfer_ok_in, external_trap_in, prefix_load_in, long_set_in} = '0;
    buffer_addr_in = '0;
    first_src_in = '0;
    void'($urandom(32'hef75));
    repeat (20) @(negedge sys_clk_in);
    `CHK({cycle_point_out, fetch_flag_out, fetch_late_out}, 5'h1c, "reset state")
    rst_in = 1'b0;
    overlap_mode_in = 1'b1;
    skip_flag_in = 1'b1;
    c = '0;
    // skip forces a fetch every cycle; vary decrement, diag, trap
    for (int i = 0; i < 9; i++) begin
      wait_pt(3'h2);
      if (i > 0) `CHK(instr_counter_out, c, "counter update")
      if (i == 8) break;
      d = (i == 2 || i == 5);
      x = (i == 7);
      decrement_in = d;
      diag_mode_in = (i == 4);
      external_trap_in = x;
      prefix_load_in = (i == 3); // prefix opcode load once
      long_set_in = (i == 6); // long set pulse once
      update_to_backup_in = 1'($urandom);
      buffer_addr_in = 15'($urandom);
      wait_pt(3'h7);
      a2 = d ? c - 15'h1 : c + 15'h1;
      if (i > 0) begin
        ow = c[0] ? word(ae) : word(ao);
        bw = c[0] ? word(ao) : word(ae);
        if (long_set_in) bw = ow; // long set repeats the opcode-side word
        if (update_to_backup_in) bw[21:35] = a2; // held next address at point 6
        if (x) `CHK(opcode_reg_out, `FC_OPC_TRAP, "store trap")
        else begin
          if (prefix_load_in)
            `CHK({opcode_reg_out[0], opcode_reg_out[8:9]}, ow[0:2], "prefix")
          else `CHK(opcode_reg_out, {ow[0], ow[3:11]}, "opcode load")
          `CHK({storage_word_reg_out, tag_field_reg_out}, {ow, ow[18:20]}, "word load")
          if (long_set_in || (c[0] ? vo : ve)) `CHK(instr_backup_reg_out, bw, "backup load")
        end
      end
      `CHK(fetch_addr_gate_out, 1'b1, "skip forces fetch")
      if (!update_to_backup_in) `CHK(addr_hold_reg_out, a2, "held next address")
      ae = c[0] ? a2 : c;
      ao = c[0] ? c : a2;
      ve = !c[0] || !diag_mode_in;
      vo = c[0] || !diag_mode_in;
      `CHK({mem_addr_even_valid_out, mem_addr_odd_valid_out}, {ve, vo}, "valids")
      if (ve) `CHK(mem_addr_even_out, ae, "even address")
      if (vo) `CHK(mem_addr_odd_out, ao, "odd address")
      if (!d) c = c + 15'h1;
    end
    {external_trap_in, decrement_in, diag_mode_in} = '0;
    // first address source selects 1 to 3; select 3 falls back to the counter
    for (int s = 1; s < 4; s++) begin
      first_src_in = 2'(s);
      wait_pt(3'h7);
      `CHK(mem_addr_even_valid_out & mem_addr_odd_valid_out, 1'b1, "pair")
      wait_pt(3'h2);
    end
    {channel_trap_in, trap_mode_in, cond_xfer_ok_in, counter_correct_in} = 4'hf;
    wait_pt(3'h7);
    `CHK(buffer_addr_in[0] ? mem_addr_odd_out : mem_addr_even_out, buffer_addr_in, "trap addr")
    wait_pt(3'h2);
    `CHK(instr_counter_out, 15'h0001, "trap transfer")
    {channel_trap_in, trap_mode_in, cond_xfer_ok_in, counter_correct_in, skip_flag_in} = '0;
    halt_transfer_op_in = 1'b1;
    wait_pt(3'h4);
    `CHK(instr_counter_out, 15'h0000, "halt decrement")
    halt_transfer_op_in = 1'b0;
    backup_needs_el_in = 1'b1;
    wait_pt(3'h6);
    `CHK({el_cycle_out, fetch_flag_out}, 2'b10, "enter e or l")
    backup_needs_el_in = 1'b0;
    overlap_conflict_in = 1'b1;
    wait_pt(3'h2);
    wait_pt(3'h6);
    `CHK(fetch_flag_out, 1'b0, "conflict waits")
    opcode_op_done_in = 1'b1;
    wait_pt(3'h2);
    wait_pt(3'h6);
    `CHK(fetch_flag_out, 1'b1, "fetch after end")
    // buffer cycles pending: flag held off, point frozen
    skip_flag_in = 1'b1;
    buffer_interrupt_in = 1'b1;
    repeat (3) @(negedge sys_clk_in);
    pf = cycle_point_out;
    repeat (12) @(negedge sys_clk_in);
    `CHK({fetch_flag_out, cycle_point_out}, {1'b0, pf}, "buffer block")
    buffer_interrupt_in = 1'b0;
    repeat (3) @(negedge sys_clk_in);
    `CHK(fetch_flag_out, 1'b1, "fetch released")
    final_report();
  end
endmodule
`default_nettype wire
